/* logic/vipm_arbiter.sv */
// Winner selection among pending vectors by priority, subpriority, order
`timescale 1ns/100ps
`default_nettype none
module vipm_arbiter #(
   parameter int NUM_VEC = 32
) (
   input wire logic [NUM_VEC-1:0] pend,
   input wire logic [NUM_VEC-1:0][2:0] prio,
   input wire logic [NUM_VEC-1:0][1:0] sub,
   output logic win_valid,
   output logic [4:0] win_vec,
   output logic [2:0] win_level,
   output logic [1:0] win_sub
);

   // Scan upward; only a strictly better key replaces the holder
   always_comb begin
      win_valid = 1'b0;
      win_vec = 5'h00;
      win_level = 3'h0;
      win_sub = 2'h0;
      for (int v = 0; v < NUM_VEC; v++) begin
         if (pend[v] && prio[v] != 3'h0 &&
             (!win_valid || {prio[v], sub[v]} > {win_level, win_sub})) begin
            win_valid = 1'b1;
            win_vec = v[4:0];
            win_level = prio[v];
            win_sub = sub[v];
         end
      end
   end

endmodule // vipm_arbiter
`default_nettype wire

/* logic/vipm_cfg.svh */
// Constants of the vectored interrupt priority map: offsets, fields, resets
`ifndef VIPM_CFG_SVH
`define VIPM_CFG_SVH

// ***************************************************
// Sizes
// ***************************************************
`define VIPM_NUM_REQ 39
`define VIPM_NUM_VEC 32
`define VIPM_NUM_PWORD 8

// ***************************************************
// Register byte offsets
// ***************************************************
`define VIPM_OFS_FLAG_LO 8'h00
`define VIPM_OFS_FLAG_HI 8'h04
`define VIPM_OFS_EN_LO 8'h08
`define VIPM_OFS_EN_HI 8'h0c
`define VIPM_OFS_VSTAT 8'h10
`define VIPM_OFS_ISTAT 8'h14
`define VIPM_OFS_IMASK 8'h18
`define VIPM_PWORD_SEL 3'h1
`define VIPM_HI_BITS 7

// ***************************************************
// Field layout of one priority slot (one byte lane)
// ***************************************************
`define VIPM_SLOT_PRI_MSB 4
`define VIPM_SLOT_SUB_MSB 1
`define VIPM_PWORD_RSVD 32'he0e0e0e0

// ***************************************************
// Persistent sources, status bits, reset values
// ***************************************************
`define VIPM_PERSIST 39'h78_1631_8c60
`define VIPM_ST_FLAGSET 0
`define VIPM_ST_TAKEN 1
`define VIPM_ST_BITS 2
`define VIPM_RST_WORD 32'h0000_0000

`endif

/* logic/vipm_pkg.sv */
// Types and request-to-vector mapping of the vectored interrupt priority map
`default_nettype none
package vipm_pkg;

   typedef logic [2:0] vipm_prio_type;
   typedef logic [1:0] vipm_sub_type;
   typedef logic [4:0] vipm_vec_type;

   typedef enum logic {
      VIPM_BUS_IDLE,
      VIPM_BUS_DONE
   } vipm_bus_state_type;

   // Maps a request number onto its vector; capture units share one
   function automatic vipm_vec_type vipm_req_to_vec(input int req);
      int v;
      begin
         if (req <= 4) begin
            v = req;
         end else if (req <= 6) begin
            v = 5;
         end else if (req <= 9) begin
            v = req - 1;
         end else if (req <= 11) begin
            v = 9;
         end else if (req <= 14) begin
            v = req - 2;
         end else if (req <= 16) begin
            v = 13;
         end else if (req <= 19) begin
            v = req - 3;
         end else if (req <= 21) begin
            v = 17;
         end else if (req <= 24) begin
            v = req - 4;
         end else if (req <= 26) begin
            v = 21;
         end else if (req <= 35) begin
            v = req - 5;
         end else begin
            v = 31;
         end
         return v[4:0];
      end
   endfunction

endpackage
`default_nettype wire

/* logic/vipm_top.sv */
// Vectored interrupt priority map with an Avalon-MM register slave
// Function
// - One pending flag and enable per request; 0-31 low words, rest high.
// - Core timer and two software interrupts use vectors 0, 1 and 2.
// - Capture error and capture event of one unit share a vector.
// - Serial fault, receive and transfer requests 36-38 all use vector 31.
// - Priority is 3 bits; levels 1 to 7, zero disables the vector.
// - Subpriority is 2 bits, ordering vectors of equal priority.
// - Each priority word holds four slots at fixed bit positions.
// - Bits 31:29, 23:21, 15:13 and 7:5 of priority words read zero.
// - Persistent sources keep their flags set while the source stays high.
// - Requests 29 to 31 map to vectors 24 to 26.
`timescale 1ns/100ps
`default_nettype none
`include "vipm_cfg.svh"
module vipm_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] avm_address,
   input wire logic avm_read,
   input wire logic avm_write,
   input wire logic [31:0] avm_writedata,
   input wire logic [3:0] avm_byteenable,
   output logic [31:0] avm_readdata,
   output logic avm_waitrequest,
   input wire logic [`VIPM_NUM_REQ-1:0] irq_src,
   input wire logic int_ack,
   output logic int_req,
   output logic [4:0] int_vector,
   output logic [2:0] int_level,
   output logic [1:0] int_sub,
   output logic irq
);

   // ***************************************************
   // Declarations
   // ***************************************************
   vipm_pkg::vipm_bus_state_type bus_state;
   logic wr_fire;
   logic rd_fire;
   logic [31:0] rd_value;
   logic [`VIPM_NUM_REQ-1:0] src_q;
   logic [`VIPM_NUM_REQ-1:0] set_ev;
   logic [`VIPM_NUM_REQ-1:0] flags;
   logic [`VIPM_NUM_REQ-1:0] enables;
   logic [`VIPM_NUM_REQ-1:0] next_flags;
   logic [`VIPM_NUM_REQ-1:0] next_enables;
   logic [`VIPM_NUM_REQ-1:0] live;
   logic [`VIPM_NUM_VEC-1:0] vec_pend;
   logic [`VIPM_NUM_VEC-1:0][2:0] prio;
   logic [`VIPM_NUM_VEC-1:0][1:0] sub;
   logic win_valid;
   logic [4:0] win_vec;
   logic [2:0] win_level;
   logic [1:0] win_sub;
   logic [`VIPM_ST_BITS-1:0] irq_stat;
   logic [`VIPM_ST_BITS-1:0] irq_mask;
   logic [`VIPM_ST_BITS-1:0] stat_ev;
   logic [`VIPM_ST_BITS-1:0] stat_seen;

   // Byte-lane merge of write data into an old word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wdata,
                                         input logic [3:0] be);
      logic [31:0] res;
      begin
         res = old;
         for (int k = 0; k < 4; k++) begin
            if (be[k]) begin
               res[8*k +: 8] = wdata[8*k +: 8];
            end
         end
         return res;
      end
   endfunction

   // ***************************************************
   // Avalon-MM slave handshake
   // ***************************************************

   // Every access waits one cycle, then completes
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bus_state <= vipm_pkg::VIPM_BUS_IDLE;
      end else begin
         case (bus_state)
            vipm_pkg::VIPM_BUS_IDLE: begin
               if (avm_read || avm_write) begin
                  bus_state <= vipm_pkg::VIPM_BUS_DONE;
               end
            end
            vipm_pkg::VIPM_BUS_DONE: begin
               bus_state <= vipm_pkg::VIPM_BUS_IDLE;
            end
            default: begin
               bus_state <= vipm_pkg::VIPM_BUS_IDLE;
            end
         endcase
      end
   end

   assign avm_waitrequest = (avm_read || avm_write) &&
                            bus_state == vipm_pkg::VIPM_BUS_IDLE;
   assign wr_fire = avm_write && bus_state == vipm_pkg::VIPM_BUS_DONE;
   assign rd_fire = avm_read && bus_state == vipm_pkg::VIPM_BUS_DONE;

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_value = `VIPM_RST_WORD;
      if (avm_address[7:5] == `VIPM_PWORD_SEL &&
          avm_address[1:0] == 2'h0) begin
         for (int k = 0; k < 4; k++) begin
            rd_value[8*k +: 8] = {3'h0,
                                  prio[{avm_address[4:2], 2'(k)}],
                                  sub[{avm_address[4:2], 2'(k)}]};
         end
      end else begin
         case (avm_address)
            `VIPM_OFS_FLAG_LO: rd_value = flags[31:0];
            `VIPM_OFS_FLAG_HI: rd_value[`VIPM_HI_BITS-1:0] = flags[38:32];
            `VIPM_OFS_EN_LO: rd_value = enables[31:0];
            `VIPM_OFS_EN_HI: rd_value[`VIPM_HI_BITS-1:0] = enables[38:32];
            `VIPM_OFS_VSTAT: rd_value[10:0] = {int_req, int_level, int_sub,
                                               int_vector};
            `VIPM_OFS_ISTAT: rd_value[`VIPM_ST_BITS-1:0] = irq_stat;
            `VIPM_OFS_IMASK: rd_value[`VIPM_ST_BITS-1:0] = irq_mask;
            default: rd_value = `VIPM_RST_WORD;
         endcase
      end
   end

   // Read data captured at the wait edge, stands at the completing edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         avm_readdata <= `VIPM_RST_WORD;
      end else if (avm_read && bus_state == vipm_pkg::VIPM_BUS_IDLE) begin
         avm_readdata <= rd_value;
      end
   end

   // ***************************************************
   // Request flags and enables
   // ***************************************************

   // Source history for edge detection
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         src_q <= '0;
      end else begin
         src_q <= irq_src;
      end
   end

   // Persistent sources set every cycle, others on a rising edge
   assign set_ev = (irq_src & `VIPM_PERSIST) |
                   (irq_src & ~src_q & ~`VIPM_PERSIST);

   // Software writes land first; hardware sets win over clears
   always_comb begin
      next_flags = flags;
      next_enables = enables;
      if (wr_fire && avm_address == `VIPM_OFS_FLAG_LO) begin
         next_flags[31:0] = merge(flags[31:0], avm_writedata,
                                  avm_byteenable);
      end
      if (wr_fire && avm_address == `VIPM_OFS_FLAG_HI) begin
         next_flags[38:32] = avm_byteenable[0] ?
                             avm_writedata[`VIPM_HI_BITS-1:0] : flags[38:32];
      end
      if (wr_fire && avm_address == `VIPM_OFS_EN_LO) begin
         next_enables[31:0] = merge(enables[31:0], avm_writedata,
                                    avm_byteenable);
      end
      if (wr_fire && avm_address == `VIPM_OFS_EN_HI) begin
         next_enables[38:32] = avm_byteenable[0] ?
                               avm_writedata[`VIPM_HI_BITS-1:0] :
                               enables[38:32];
      end
   end

   // Flag and enable storage
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         flags <= '0;
         enables <= '0;
      end else begin
         flags <= next_flags | set_ev;
         enables <= next_enables;
      end
   end

   // ***************************************************
   // Priority words
   // ***************************************************

   // Byte lane k of word w is slot 4w+k
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prio <= '0;
         sub <= '0;
      end else begin
         for (int w = 0; w < `VIPM_NUM_PWORD; w++) begin
            for (int k = 0; k < 4; k++) begin
               if (wr_fire && avm_address == {`VIPM_PWORD_SEL, 3'(w), 2'h0} &&
                   avm_byteenable[k]) begin
                  prio[4*w+k] <=
                     avm_writedata[8*k+`VIPM_SLOT_PRI_MSB -: 3];
                  sub[4*w+k] <=
                     avm_writedata[8*k+`VIPM_SLOT_SUB_MSB -: 2];
               end
            end
         end
      end
   end

   // ***************************************************
   // Vector mapping and selection
   // ***************************************************

   assign live = flags & enables;

   // Shared vectors OR their requests together
   always_comb begin
      vec_pend = '0;
      for (int r = 0; r < `VIPM_NUM_REQ; r++) begin
         vec_pend[vipm_pkg::vipm_req_to_vec(r)] =
            vec_pend[vipm_pkg::vipm_req_to_vec(r)] | live[r];
      end
   end

   vipm_arbiter #(
      .NUM_VEC(`VIPM_NUM_VEC)
   ) u_arbiter (
      .pend(vec_pend),
      .prio(prio),
      .sub(sub),
      .win_valid(win_valid),
      .win_vec(win_vec),
      .win_level(win_level),
      .win_sub(win_sub)
   );

   // Registered presentation to the core
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         int_req <= 1'b0;
         int_vector <= 5'h00;
         int_level <= 3'h0;
         int_sub <= 2'h0;
      end else begin
         int_req <= win_valid;
         int_vector <= win_vec;
         int_level <= win_level;
         int_sub <= win_sub;
      end
   end

   // ***************************************************
   // Block interrupt: sticky status, mask, read-clear
   // ***************************************************

   assign stat_ev[`VIPM_ST_FLAGSET] = |(set_ev & ~flags);
   assign stat_ev[`VIPM_ST_TAKEN] = int_ack && int_req;
   assign stat_seen = avm_readdata[`VIPM_ST_BITS-1:0];

   // Only bits returned by the read are cleared; new events win
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_stat <= '0;
      end else if (rd_fire && avm_address == `VIPM_OFS_ISTAT) begin
         irq_stat <= stat_ev | (irq_stat & ~stat_seen);
      end else begin
         irq_stat <= stat_ev | irq_stat;
      end
   end

   // Mask register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_mask <= '0;
      end else if (wr_fire && avm_address == `VIPM_OFS_IMASK &&
                   avm_byteenable[0]) begin
         irq_mask <= avm_writedata[`VIPM_ST_BITS-1:0];
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // ***************************************************
   // Assertions
   // ***************************************************

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_persist_hold: assert property (
      irq_src[5] |=> flags[5])
      else $error("persistent capture flag not held");

   a_edge_set_flag: assert property (
      !irq_src[7] ##1 irq_src[7] |=> flags[7])
      else $error("rising source did not set its flag");

   a_capture_shared: assert property (
      live[6] && !live[5] && vec_pend[4:0] == 5'h00 &&
      vec_pend[31:6] == '0 && prio[5] != 3'h0
      |=> int_req && int_vector == 5'd5)
      else $error("capture event not delivered on shared vector");

   a_serial_vector: assert property (
      live[37] && vec_pend[30:0] == '0 && prio[31] != 3'h0
      |=> int_req && int_vector == 5'd31)
      else $error("serial request not on vector 31");

   a_timer_wins: assert property (
      live[0] && prio[0] == 3'h7 && sub[0] == 2'h3
      |=> int_req && int_vector == 5'd0)
      else $error("top-keyed core timer lost arbitration");

   a_rtcc_map: assert property (
      live == (39'h1 << 30) && prio[25] != 3'h0
      |=> int_req && int_vector == 5'd25 && int_level == $past(prio[25]))
      else $error("request 30 not on vector 25");

   a_zero_blocks: assert property (
      int_req |-> int_level != 3'h0)
      else $error("disabled priority presented");

   a_tie_lowest: assert property (
      vec_pend == 32'h0000_0048 && prio[3] == prio[6] &&
      sub[3] == sub[6] && prio[3] != 3'h0
      |=> int_vector == 5'd3)
      else $error("tie not broken by natural order");

   a_sub_orders: assert property (
      vec_pend == 32'h0000_0048 && prio[3] == prio[6] && prio[3] != 3'h0 &&
      sub[6] > sub[3] |=> int_vector == 5'd6)
      else $error("subpriority ignored");

   a_reserved_zero: assert property (
      avm_read && !avm_waitrequest && avm_address[7:5] == `VIPM_PWORD_SEL
      |-> (avm_readdata & `VIPM_PWORD_RSVD) == 32'h0)
      else $error("reserved priority bits read nonzero");

   a_needs_enable: assert property (
      vec_pend == '0 ##1 vec_pend == '0 |=> !int_req)
      else $error("request presented with nothing live");

   c_serial_taken: cover property (int_req && int_vector == 5'd31 ##1 int_ack);
   c_stat_read: cover property (rd_fire && avm_address == `VIPM_OFS_ISTAT &&
                                irq_stat != '0);
   c_irq_line: cover property (irq ##[1:20] !irq);

endmodule // vipm_top
`default_nettype wire

/* testbench/vipm_core_model.sv */
// Processor core model that takes presented vectors after a set delay
`timescale 1ns/100ps
`default_nettype none
module vipm_core_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic accept,
   input wire logic [3:0] ack_delay,
   input wire logic int_req,
   input wire logic [4:0] int_vector,
   output logic int_ack,
   output logic taken,
   output logic [4:0] taken_vec
);
   // ****************************************
   // Vector intake
   // ****************************************
   logic [3:0] wait_cnt;

   // One acknowledge pulse per presentation, prompt or slow
   always_ff @(posedge mclk) begin
      int_ack <= 1'b0;
      if (!rst_n || !int_req) begin
         wait_cnt <= 4'h0;
         taken <= 1'b0;
         taken_vec <= 5'h00;
      end else if (accept && !taken && wait_cnt >= ack_delay) begin
         int_ack <= 1'b1; // Only flagged, enabled vectors of nonzero priority
         taken <= 1'b1;
         taken_vec <= int_vector;
      end else if (accept && !taken) begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule // vipm_core_model
`default_nettype wire

/* testbench/vipm_top_tb.sv */
// Self-checking bench of the vectored interrupt priority map
`timescale 1ns/100ps
`default_nettype none
`include "vipm_cfg.svh"
module vipm_top_tb;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic mclk, rst_n, avm_read, avm_write, avm_waitrequest;
   logic [7:0] avm_address;
   logic [31:0] avm_writedata, avm_readdata, rdata;
   logic [3:0] avm_byteenable, ack_delay;
   logic [`VIPM_NUM_REQ-1:0] irq_src;
   logic int_ack, int_req, irq, accept, taken;
   logic [4:0] int_vector, taken_vec;
   logic [2:0] int_level;
   logic [1:0] int_sub;
   int errors, checks;
   logic [2:0] pa [5] = '{3'h2, 3'h5, 3'h5, 3'h4, 3'h0};
   logic [1:0] sa [5] = '{2'h0, 2'h3, 2'h1, 2'h2, 2'h3};
   logic [2:0] pb [5] = '{3'h5, 3'h5, 3'h5, 3'h4, 3'h1};
   logic [1:0] sb [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
   logic [4:0] wv [5] = '{5'h06, 5'h03, 5'h06, 5'h03, 5'h06};

   vipm_top DUT (.mclk(mclk), .rst_n(rst_n), .avm_address(avm_address),
      .avm_read(avm_read), .avm_write(avm_write),
      .avm_writedata(avm_writedata), .avm_byteenable(avm_byteenable),
      .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
      .irq_src(irq_src), .int_ack(int_ack), .int_req(int_req),
      .int_vector(int_vector), .int_level(int_level), .int_sub(int_sub),
      .irq(irq));

   vipm_core_model core (.mclk(mclk), .rst_n(rst_n), .accept(accept),
      .ack_delay(ack_delay), .int_req(int_req), .int_vector(int_vector),
      .int_ack(int_ack), .taken(taken), .taken_vec(taken_vec));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         checks++;
         if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   // Avalon access held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] wd);
      begin
         @(posedge mclk);
         avm_address <= a;
         avm_writedata <= wd;
         avm_write <= wr;
         avm_read <= !wr;
         do begin
            @(posedge mclk);
         end while (avm_waitrequest !== 1'b0);
         rdata = avm_readdata;
         avm_read <= 1'b0;
         avm_write <= 1'b0;
      end
   endtask

   // One-cycle source pulse, then two edges for flag and presentation
   task automatic pulse(input int r);
      begin
         @(posedge mclk);
         irq_src[r] <= 1'b1;
         @(posedge mclk);
         irq_src[r] <= 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask

   function automatic logic [4:0] exp_vec(input int r);
      int v;
      begin
         v = r - (r >= 6) - (r >= 11) - (r >= 16) - (r >= 21) - (r >= 26);
         if (r > 36) v = 31;
         return v[4:0];
      end
   endfunction

   task automatic test_done;
      begin
         $display("Counts: checks=%0d errors=%0d", checks, errors);
         if (errors == 0 && checks > 0) begin
            $display("All checks passed");
         end else begin
            $display("Checks failed");
         end
         $finish;
      end
   endtask

   // ****************************************
   // Clock, watchdog and tests
   // ****************************************
   // Free running 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Cuts a hang short well beyond the expected run
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      test_done;
   end

   // Test sequence
   initial begin
      errors = 0;
      checks = 0;
      rst_n = 1'b0;
      avm_address = 8'h00;
      avm_read = 1'b0;
      avm_write = 1'b0;
      avm_writedata = 32'h0;
      avm_byteenable = 4'hf;
      irq_src = '0;
      accept = 1'b1;
      ack_delay = 4'h0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      for (int a = 0; a <= 'h40; a += 4) begin
         bus(1'b0, a[7:0], 32'h0);
         chk(rdata, 32'h0);
      end
      bus(1'b1, 8'h40, 32'hffffffff);
      bus(1'b0, 8'h40, 32'h0);
      chk(rdata, 32'h0);
      $display("Test reset and unmapped done");
      for (int w = 0; w < 8; w++) begin
         bus(1'b1, 8'h20 + 8'(w * 4), 32'hffffffff);
         bus(1'b0, 8'h20 + 8'(w * 4), 32'h0);
         chk(rdata, 32'h1f1f1f1f);
         bus(1'b1, 8'h20 + 8'(w * 4), 32'h1c1c1c1c);
      end
      avm_byteenable <= 4'h2;
      bus(1'b1, 8'h20, 32'hffff04ff);
      avm_byteenable <= 4'hf;
      bus(1'b0, 8'h20, 32'h0);
      chk(rdata, 32'h1c1c041c);
      bus(1'b1, 8'h20, 32'h1c1c1c1c);
      bus(1'b1, 8'h08, 32'hffffffff);
      bus(1'b1, 8'h0c, 32'hffffffff);
      bus(1'b0, 8'h0c, 32'h0);
      chk(rdata, 32'h7f);
      $display("Test priority words done");
      for (int r = 0; r < `VIPM_NUM_REQ; r++) begin
         ack_delay <= {3'h0, r[0]};
         pulse(r);
         chk(int_req, 1'b1);
         chk(int_vector, exp_vec(r));
         bus(1'b0, r < 32 ? 8'h00 : 8'h04, 32'h0);
         chk(rdata, 32'h1 << (r % 32));
         bus(1'b0, 8'h10, 32'h0);
         chk(rdata, {21'h0, 1'b1, 3'h7, 2'h0, exp_vec(r)});
         chk(taken_vec, exp_vec(r));
         bus(1'b1, r < 32 ? 8'h00 : 8'h04, 32'h0);
         repeat (2) @(posedge mclk);
         chk(int_req, 1'b0);
      end
      $display("Test request mapping done");
      pulse(3);
      pulse(7);
      for (int k = 0; k < 5; k++) begin
         bus(1'b1, 8'h20, {3'h0, pa[k], sa[k], 24'h0});
         bus(1'b1, 8'h24, {11'h0, pb[k], sb[k], 16'h0});
         repeat (2) @(posedge mclk);
         chk(int_vector, wv[k]);
         chk(int_level, wv[k] == 5'h03 ? pa[k] : pb[k]);
         chk(int_sub, wv[k] == 5'h03 ? sa[k] : sb[k]);
      end
      bus(1'b1, 8'h08, 32'hffffff7f);
      repeat (2) @(posedge mclk);
      chk(int_req, 1'b0);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h08, 32'hffffffff);
      bus(1'b1, 8'h20, 32'h1c1c1c1f);
      $display("Test arbitration done");
      accept <= 1'b0;
      bus(1'b1, 8'h18, 32'h0);
      bus(1'b0, 8'h14, 32'h0);
      pulse(0);
      chk(int_sub, 2'h3);
      chk(irq, 1'b0);
      bus(1'b1, 8'h18, 32'h1);
      @(posedge mclk);
      chk(irq, 1'b1);
      bus(1'b0, 8'h14, 32'h0);
      chk(rdata, 32'h1);
      @(posedge mclk);
      chk(irq, 1'b0);
      accept <= 1'b1;
      repeat (4) @(posedge mclk);
      chk(taken, 1'b1);
      bus(1'b0, 8'h14, 32'h0);
      chk(rdata, 32'h2);
      bus(1'b1, 8'h00, 32'h0);
      $display("Test status and mask done");
      @(posedge mclk);
      irq_src[28] <= 1'b1;
      irq_src[27] <= 1'b1;
      repeat (2) @(posedge mclk);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b0, 8'h00, 32'h0);
      chk(rdata, 32'h1000_0000);
      irq_src <= '0;
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b0, 8'h00, 32'h0);
      chk(rdata, 32'h0);
      $display("Test persistent sources done");
      test_done;
   end
endmodule // vipm_top_tb
`default_nettype wire
